// [verilog/uus_user_unit_scaling.sv]
/*
 User-unit scaling: unit-select objects, conversion factors and the
 resulting scales between user units and motor increments.
 Assumes a single-cycle object port from the fieldbus side and drive
 state inputs synchronous to ref_clk.
*/
`timescale 1ns/1ps
`include "uus_defs.svh"
module uus_user_unit_scaling #(
   parameter int NSLOT = 17
) (
   // Clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   rst,
   // Object access
   input  wire logic                   objWr,
   input  wire logic                   objRd,
   input  wire uus_pkg::uus_obj_req_t  objReq,
   output logic                        objAck,
   output logic                        objAbort,
   output logic [31:0]                 objRdData,
   // Drive state
   input  wire logic                   opEnabled,
   input  wire logic                   velocityMode,
   input  wire logic                   openLoop,
   input  wire logic                   threePhase,
   // Scaling results
   output uus_pkg::uus_pos_info_t      posInfo,
   output uus_pkg::uus_spd_info_t      spdInfo,
   output uus_pkg::uus_ratios_t        ratios,
   output logic                        cfgPending,
   output logic                        calcBusy
);

   generate
      if (NSLOT != 17)
         $error("uus_user_unit_scaling: slot count fixed at 17");
   endgenerate

   localparam logic [4:0] S_POS = 5'h00;
   localparam logic [4:0] S_SPD = 5'h01;
   localparam logic [4:0] S_PP  = 5'h10;

   logic [31:0]        pendFf [NSLOT];
   logic [31:0]        actFf  [NSLOT];
   logic [47:0]        resFf  [7];
   logic [6:0]         zeroFf;
   logic               dirtyFf;
   uus_pkg::uus_state_t stateFf;
   logic [2:0]         rIdxFf;
   logic               divStart;
   logic               divBusy;
   logic               divDone;
   logic [47:0]        divQuot;
   logic               divZero;
   logic [5:0]         hit;
   logic               wrOk;
   logic               apply;

   // Object address to storage slot; bit 5 flags a hit
   function automatic logic [5:0] objSlot(input logic [15:0] idx,
                                          input logic [7:0]  sub);
      logic [5:0] s;
      s = 6'h00;
      if (sub == `UUS_SUB_VALUE)
         case (idx)
            `UUS_IDX_POS_UNIT  : s = 6'h20;
            `UUS_IDX_SPD_UNIT  : s = 6'h21;
            `UUS_IDX_ENC_INC   : s = 6'h2A;
            `UUS_IDX_ENC_REV   : s = 6'h2B;
            `UUS_IDX_GEAR_MOT  : s = 6'h2C;
            `UUS_IDX_GEAR_DRV  : s = 6'h2D;
            `UUS_IDX_FEED      : s = 6'h2E;
            `UUS_IDX_FEED_REV  : s = 6'h2F;
            `UUS_IDX_POLE_PAIR : s = 6'h30;
            default            : s = 6'h00;
         endcase
      else if (sub == `UUS_SUB_NUM || sub == `UUS_SUB_DEN)
         case (idx)
            `UUS_IDX_SPD_CONV : s = {5'h11, sub == `UUS_SUB_DEN};
            `UUS_IDX_ACC_CONV : s = {5'h12, sub == `UUS_SUB_DEN};
            `UUS_IDX_JRK_CONV : s = {5'h13, sub == `UUS_SUB_DEN};
            `UUS_IDX_VM_SCALE : s = {5'h14, sub == `UUS_SUB_DEN};
            default           : s = 6'h00;
         endcase
      return s;
   endfunction

   function automatic logic posCodeOk(input logic [7:0] c);
      case (c)
         `UUS_U_DIMLESS, `UUS_U_METER, `UUS_U_INCH, `UUS_U_FOOT,
         `UUS_U_GRADIAN, `UUS_U_RADIAN, `UUS_U_DEGREE, `UUS_U_ARCMIN,
         `UUS_U_ARCSEC, `UUS_U_REV, `UUS_U_ENC_INC, `UUS_U_STEP,
         `UUS_U_POLE : return 1'b1;
         default     : return 1'b0;
      endcase
   endfunction

   function automatic logic isLength(input logic [7:0] c);
      return c == `UUS_U_METER || c == `UUS_U_INCH ||
             c == `UUS_U_FOOT || c == `UUS_U_DIMLESS;
   endfunction

   function automatic logic isAngular(input logic [7:0] c);
      return c == `UUS_U_GRADIAN || c == `UUS_U_RADIAN ||
             c == `UUS_U_DEGREE || c == `UUS_U_ARCMIN ||
             c == `UUS_U_ARCSEC || c == `UUS_U_REV;
   endfunction

   // Seconds per time unit; zero marks an unknown code
   function automatic logic [31:0] secPer(input logic [7:0] t);
      case (t)
         `UUS_T_SEC  : return 32'h00000001;
         `UUS_T_MIN  : return `UUS_SEC_MIN;
         `UUS_T_HOUR : return `UUS_SEC_HOUR;
         `UUS_T_DAY  : return `UUS_SEC_DAY;
         `UUS_T_YEAR : return `UUS_SEC_YEAR;
         default     : return 32'h00000000;
      endcase
   endfunction

   function automatic logic expOk(input logic [7:0] e);
      return $signed(e) <= $signed(`UUS_EXP_MAX) &&
             $signed(e) >= $signed(`UUS_EXP_MIN);
   endfunction

   function automatic logic [31:0] rstVal(input int s);
      if (s == int'(S_POS))
         return `UUS_RST_POS_UNIT;
      else if (s == int'(S_SPD))
         return `UUS_RST_SPD_UNIT;
      return `UUS_RST_FACTOR;
   endfunction

   // Writes are refused when a code or exponent is outside the tables
   function automatic logic valueOk(input logic [5:0]  s,
                                    input logic [31:0] d);
      if (s[4:0] == S_POS)
         return posCodeOk(d[`UUS_UNIT_LSB +: 8]) &&
                expOk(d[`UUS_EXP_LSB +: 8]);
      else if (s[4:0] == S_SPD)
         return posCodeOk(d[`UUS_UNIT_LSB +: 8]) &&
                secPer(d[`UUS_TIME_LSB +: 8]) != 32'h00000000 &&
                expOk(d[`UUS_EXP_LSB +: 8]);
      return 1'b1;
   endfunction

   assign hit   = objSlot(objReq.index, objReq.sub);
   assign wrOk  = objWr && hit[5] && valueOk(hit, objReq.data);
   assign apply = dirtyFf && !opEnabled && stateFf == uus_pkg::UUS_IDLE;

   // Object port answers one cycle after the strobe
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         objAck    <= 1'b0;
         objAbort  <= 1'b0;
         objRdData <= 32'h00000000;
      end
      else
      begin
         objAck    <= objWr || objRd;
         objAbort  <= (objWr && !wrOk) || (objRd && !objWr && !hit[5]);
         objRdData <= (objRd && !objWr && hit[5]) ? pendFf[hit[4:0]] : 32'h00000000;
      end
   end

   // Pending copy takes writes; reserved bits are stored as zero
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < NSLOT; i++)
            pendFf[i] <= rstVal(i);
      end
      else if (wrOk)
      begin
         if (hit[4:0] == S_POS)
            pendFf[hit[4:0]] <= objReq.data & `UUS_POS_RSV_MASK;
         else if (hit[4:0] == S_SPD)
            pendFf[hit[4:0]] <= objReq.data & `UUS_SPD_RSV_MASK;
         else
            pendFf[hit[4:0]] <= objReq.data;
      end
   end

   // A write in the apply cycle keeps the pending flag set
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         dirtyFf <= 1'b0;
      else if (wrOk)
         dirtyFf <= 1'b1;
      else if (apply)
         dirtyFf <= 1'b0;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < NSLOT; i++)
            actFf[i] <= rstVal(i);
      end
      else if (apply)
      begin
         for (int i = 0; i < NSLOT; i++)
            actFf[i] <= pendFf[i];
      end
   end

   // Ratio k uses numerator slot 2k+10 for k up to 2 and 2k-4 from k=3 on; table kept small
   function automatic logic [4:0] numSlot(input logic [2:0] k);
      case (k)
         3'h0    : return 5'h0A;
         3'h1    : return 5'h0C;
         3'h2    : return 5'h0E;
         3'h3    : return 5'h02;
         3'h4    : return 5'h04;
         3'h5    : return 5'h06;
         default : return 5'h08;
      endcase
   endfunction

   // One shared divider walks the seven ratios after each apply
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         stateFf <= uus_pkg::UUS_IDLE;
         rIdxFf  <= 3'h0;
      end
      else
         case (stateFf)
            uus_pkg::UUS_IDLE :
               if (apply)
               begin
                  stateFf <= uus_pkg::UUS_ISSUE;
                  rIdxFf  <= 3'h0;
               end
            uus_pkg::UUS_ISSUE :
               stateFf <= uus_pkg::UUS_WAIT;
            uus_pkg::UUS_WAIT :
               if (divDone)
               begin
                  stateFf <= (rIdxFf == 3'h6) ? uus_pkg::UUS_IDLE
                                              : uus_pkg::UUS_ISSUE;
                  rIdxFf  <= rIdxFf + 3'h1;
               end
            default :
               stateFf <= uus_pkg::UUS_IDLE;
         endcase
   end

   assign divStart = stateFf == uus_pkg::UUS_ISSUE;
   assign calcBusy = stateFf != uus_pkg::UUS_IDLE;

   uus_ratio_div #(
      .W (32),
      .F (16)
   ) uDiv (
      .ref_clk (ref_clk),
      .rst     (rst),
      .start   (divStart),
      .num     (actFf[numSlot(rIdxFf)]),
      .den     (actFf[numSlot(rIdxFf) + 5'h01]),
      .busy    (divBusy),
      .done    (divDone),
      .quot    (divQuot),
      .divZero (divZero)
   );

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < 7; i++)
            resFf[i] <= `UUS_ENC_OPEN_MUL;
         zeroFf <= 7'h00;
      end
      else if (stateFf == uus_pkg::UUS_WAIT && divDone)
      begin
         resFf[rIdxFf]  <= divQuot;
         zeroFf[rIdxFf] <= divZero;
      end
   end

   assign ratios = '{enc: resFf[0], gear: resFf[1], feed: resFf[2],
                     spd: resFf[3], acc: resFf[4], jrk: resFf[5],
                     vm: resFf[6], divZero: zeroFf};

   // User units per motor revolution, Q16; gear and feed are applied
   // downstream and only where the flags say so
   logic [7:0]  posCode;
   logic [47:0] pp48;
   logic [47:0] perRev;
   assign posCode = actFf[S_POS][`UUS_UNIT_LSB +: 8];
   assign pp48    = {16'h0000, actFf[S_PP]};

   always_comb
   begin
      perRev = resFf[2];
      case (posCode)
         `UUS_U_GRADIAN : perRev = {`UUS_PR_GRADIAN, 16'h0000};
         `UUS_U_DEGREE  : perRev = {`UUS_PR_DEGREE, 16'h0000};
         `UUS_U_ARCMIN  : perRev = {`UUS_PR_ARCMIN, 16'h0000};
         `UUS_U_ARCSEC  : perRev = {`UUS_PR_ARCSEC, 16'h0000};
         `UUS_U_RADIAN  : perRev = `UUS_PR_RADIAN_Q16;
         `UUS_U_REV     : perRev = {32'h00000001, 16'h0000};
         `UUS_U_ENC_INC :
            perRev = openLoop ? 48'(pp48 * `UUS_ENC_OPEN_MUL) << 16
                              : resFf[0];
         `UUS_U_STEP    :
            perRev = 48'(pp48 * (threePhase ? `UUS_STEP_3PH
                                            : `UUS_STEP_2PH)) << 16;
         `UUS_U_POLE    : perRev = pp48 << 16;
         default        : perRev = resFf[2];
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         posInfo <= '0;
         spdInfo <= '0;
      end
      else
      begin
         posInfo.code      <= posCode;
         posInfo.expo      <= actFf[S_POS][`UUS_EXP_LSB +: 8];
         posInfo.useGear   <= isLength(posCode) || isAngular(posCode);
         posInfo.useFeed   <= isLength(posCode);
         posInfo.perRevQ16 <= perRev;
         if (velocityMode)
         begin
            spdInfo.posCode    <= `UUS_U_REV;
            spdInfo.timeCode   <= `UUS_T_MIN;
            spdInfo.expo       <= 8'h00;
            spdInfo.secPerUnit <= `UUS_SEC_MIN;
         end
         else
         begin
            spdInfo.posCode    <= actFf[S_SPD][`UUS_UNIT_LSB +: 8];
            spdInfo.timeCode   <= actFf[S_SPD][`UUS_TIME_LSB +: 8];
            spdInfo.expo       <= actFf[S_SPD][`UUS_EXP_LSB +: 8];
            spdInfo.secPerUnit <= secPer(actFf[S_SPD][`UUS_TIME_LSB +: 8]);
         end
      end
   end

   assign cfgPending = dirtyFf;

   AST_DEFER : assert property (@(posedge ref_clk) disable iff (rst)
      opEnabled |=> actFf[S_POS] == $past(actFf[S_POS]))
      else $error("unit object applied while operation enabled");

   AST_APPLY : assert property (@(posedge ref_clk) disable iff (rst)
      apply |=> actFf[S_SPD] == $past(pendFf[S_SPD]) ##1 calcBusy)
      else $error("pending values not applied");

   AST_LENGTH : assert property (@(posedge ref_clk) disable iff (rst)
      isLength(posCode) |=> posInfo.useGear && posInfo.useFeed)
      else $error("length unit lost gear or feed");

   AST_ANGLE : assert property (@(posedge ref_clk) disable iff (rst)
      (posCode == `UUS_U_DEGREE) |=>
         !posInfo.useFeed && posInfo.perRevQ16 == 48'h000001680000)
      else $error("degree scaling wrong");

   AST_ENCINC : assert property (@(posedge ref_clk) disable iff (rst)
      (posCode == `UUS_U_ENC_INC && openLoop) |=>
         !posInfo.useGear && posInfo.perRevQ16 == $past(pp48) << 32)
      else $error("open-loop increment scaling wrong");

   AST_STEP : assert property (@(posedge ref_clk) disable iff (rst)
      (posCode == `UUS_U_STEP && threePhase) |=>
         posInfo.perRevQ16 == 48'($past(pp48) * 48'h6) << 16)
      else $error("step scaling wrong");

   AST_YEAR : assert property (@(posedge ref_clk) disable iff (rst)
      (!velocityMode && actFf[S_SPD][15:8] == `UUS_T_YEAR) |=>
         spdInfo.secPerUnit == 32'd31557600)
      else $error("year length wrong");

   AST_VMODE : assert property (@(posedge ref_clk) disable iff (rst)
      velocityMode |=> spdInfo.posCode == 8'hB4 && spdInfo.timeCode == 8'h47)
      else $error("velocity mode unit not rpm");

   AST_BADEXP : assert property (@(posedge ref_clk) disable iff (rst)
      (objWr && hit[4:0] == S_POS && hit[5] &&
       $signed(objReq.data[31:24]) < -8'sd6) |=> objAck && objAbort)
      else $error("out-of-range exponent accepted");

   COV_DEFERRED : cover property (@(posedge ref_clk) disable iff (rst)
      dirtyFf && opEnabled ##1 apply);
   COV_CALC_DONE : cover property (@(posedge ref_clk) disable iff (rst)
      stateFf == uus_pkg::UUS_WAIT && divDone && rIdxFf == 3'h6);
   COV_ABORT : cover property (@(posedge ref_clk) disable iff (rst)
      objAbort);

endmodule

// [verilog/uus_defs.svh]
/*
 Constants of the user-unit scaling block: object addresses,
 field positions, reset values, unit codes and timing counts.
 Assumes inclusion by bare name from design files only.
*/
`ifndef UUS_DEFS_SVH
`define UUS_DEFS_SVH

`define UUS_IDX_POS_UNIT  16'h60A8
`define UUS_IDX_SPD_UNIT  16'h60A9
`define UUS_IDX_VM_SCALE  16'h604C
`define UUS_IDX_SPD_CONV  16'h6096
`define UUS_IDX_ACC_CONV  16'h6097
`define UUS_IDX_JRK_CONV  16'h60A2
`define UUS_IDX_ENC_INC   16'h60E6
`define UUS_IDX_ENC_REV   16'h60EB
`define UUS_IDX_GEAR_MOT  16'h60E8
`define UUS_IDX_GEAR_DRV  16'h60ED
`define UUS_IDX_FEED      16'h60E9
`define UUS_IDX_FEED_REV  16'h60EE
`define UUS_IDX_POLE_PAIR 16'h2030
`define UUS_SUB_VALUE     8'h00
`define UUS_SUB_NUM       8'h01
`define UUS_SUB_DEN       8'h02

`define UUS_EXP_LSB       24
`define UUS_UNIT_LSB      16
`define UUS_TIME_LSB      8
`define UUS_POS_RSV_MASK  32'hFFFF0000
`define UUS_SPD_RSV_MASK  32'hFFFFFF00

`define UUS_RST_POS_UNIT  32'hFF410000
`define UUS_RST_SPD_UNIT  32'h00B44700
`define UUS_RST_FACTOR    32'h00000001

`define UUS_U_DIMLESS     8'h00
`define UUS_U_METER       8'h01
`define UUS_U_INCH        8'hC1
`define UUS_U_FOOT        8'hC2
`define UUS_U_GRADIAN     8'h40
`define UUS_U_RADIAN      8'h10
`define UUS_U_DEGREE      8'h41
`define UUS_U_ARCMIN      8'h42
`define UUS_U_ARCSEC      8'h43
`define UUS_U_REV         8'hB4
`define UUS_U_ENC_INC     8'hB5
`define UUS_U_STEP        8'hAC
`define UUS_U_POLE        8'hC0
`define UUS_T_SEC         8'h03
`define UUS_T_MIN         8'h47
`define UUS_T_HOUR        8'h48
`define UUS_T_DAY         8'h49
`define UUS_T_YEAR        8'h4A
`define UUS_EXP_MAX       8'h06
`define UUS_EXP_MIN       8'hFA

`define UUS_SEC_MIN       32'h0000003C
`define UUS_SEC_HOUR      32'h00000E10
`define UUS_SEC_DAY       32'h00015180
`define UUS_SEC_YEAR      32'h01E187E0
`define UUS_PR_GRADIAN    32'h00000190
`define UUS_PR_DEGREE     32'h00000168
`define UUS_PR_ARCMIN     32'h00005460
`define UUS_PR_ARCSEC     32'h0013C680
`define UUS_PR_RADIAN_Q16 48'h000000064877
`define UUS_ENC_OPEN_MUL  48'h000000010000
`define UUS_STEP_2PH      48'h000000000004
`define UUS_STEP_3PH      48'h000000000006
`define UUS_DIV_CYCLES    48

`endif

// [verilog/uus_pkg.sv]
/*
 Types of the user-unit scaling block.
 Assumes uus_defs.svh supplies the numeric constants.
*/
package uus_pkg;

   typedef enum logic [2:0] {
      UUS_IDLE  = 3'b001,
      UUS_ISSUE = 3'b010,
      UUS_WAIT  = 3'b100
   } uus_state_t;

   typedef struct packed {
      logic [15:0] index;
      logic [7:0]  sub;
      logic [31:0] data;
   } uus_obj_req_t;

   typedef struct packed {
      logic [7:0]  code;
      logic [7:0]  expo;
      logic        useGear;
      logic        useFeed;
      logic [47:0] perRevQ16;
   } uus_pos_info_t;

   typedef struct packed {
      logic [7:0]  posCode;
      logic [7:0]  timeCode;
      logic [7:0]  expo;
      logic [31:0] secPerUnit;
   } uus_spd_info_t;

   typedef struct packed {
      logic [47:0] enc;
      logic [47:0] gear;
      logic [47:0] feed;
      logic [47:0] spd;
      logic [47:0] acc;
      logic [47:0] jrk;
      logic [47:0] vm;
      logic [6:0]  divZero;
   } uus_ratios_t;

endpackage

// [verilog/uus_ratio_div.sv]
/*
 Sequential restoring divider giving num/den as unsigned fixed point
 with F fraction bits. Assumes start is only raised while not busy.
*/
`timescale 1ns/1ps
`include "uus_defs.svh"
module uus_ratio_div #(
   parameter int W = 32,
   parameter int F = 16
) (
   // Clock and reset
   input  wire logic           ref_clk,
   input  wire logic           rst,
   // Request
   input  wire logic           start,
   input  wire logic [W-1:0]   num,
   input  wire logic [W-1:0]   den,
   // Answer
   output logic                busy,
   output logic                done,
   output logic [W+F-1:0]      quot,
   output logic                divZero
);

   localparam int N = W + F;

   generate
      if (W < 8 || F > W || N != `UUS_DIV_CYCLES)
         $error("uus_ratio_div: unsupported width");
   endgenerate

   logic [W-1:0] remFf;
   logic [N-1:0] dvdFf;
   logic [7:0]   cntFf;
   logic [W:0]   remShift;
   logic         fits;

   assign remShift = {remFf, dvdFf[N-1]};
   assign fits     = remShift >= {1'b0, den};

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         busy    <= 1'b0;
         done    <= 1'b0;
         quot    <= '0;
         divZero <= 1'b0;
         remFf   <= '0;
         dvdFf   <= '0;
         cntFf   <= 8'h00;
      end
      else
      begin
         done <= 1'b0;
         if (start && !busy)
         begin
            if (den == '0)
            begin
               // A zero denominator answers at once with zero
               done    <= 1'b1;
               divZero <= 1'b1;
               quot    <= '0;
            end
            else
            begin
               busy    <= 1'b1;
               divZero <= 1'b0;
               remFf   <= '0;
               dvdFf   <= {num, {F{1'b0}}};
               cntFf   <= 8'(N);
            end
         end
         else if (busy)
         begin
            remFf <= fits ? W'(remShift - {1'b0, den}) : remShift[W-1:0];
            dvdFf <= {dvdFf[N-2:0], fits};
            cntFf <= cntFf - 8'h01;
            if (cntFf == 8'h01)
            begin
               busy <= 1'b0;
               done <= 1'b1;
               quot <= {dvdFf[N-2:0], fits};
            end
         end
      end
   end

   AST_DIV_TIME : assert property (@(posedge ref_clk) disable iff (rst)
      (start && !busy && den != '0) |-> ##49 done)
      else $error("divider did not finish in time");

endmodule

// [test/uus_master_model.sv]
/*
 Fieldbus master model issuing one object request at a time.
 Assumes the bench calls access() only while no request is open.
*/
`timescale 1ns/1ps
module uus_master_model (
   // Clock
   input  wire logic             ref_clk,
   // Object port
   output logic                  objWr,
   output logic                  objRd,
   output uus_pkg::uus_obj_req_t objReq,
   input  wire logic             objAck,
   input  wire logic             objAbort,
   input  wire logic [31:0]      objRdData
);
   initial
   begin
      objWr = 1'b0;
      objRd = 1'b0;
      objReq = '0;
   end
   // Units requested by the bench are sent as given, including ones outside the resolution range
   task automatic access(input logic w, input logic [15:0] idx, input logic [7:0] sub,
      input logic [31:0] dat, output logic [31:0] rd, output logic ab);
      int i;
      @(posedge ref_clk) #1;
      objWr = w;
      objRd = !w;
      objReq = '{idx, sub, dat};
      @(posedge ref_clk) #1;
      objWr = 1'b0;
      objRd = 1'b0;
      // Idle lines carry the inverse so stale data never looks fresh
      objReq = ~objReq;
      for (i = 0; i < 4 && objAck !== 1'b1; i++)
         @(posedge ref_clk) #1;
      rd = objRdData;
      ab = (objAck === 1'b1) ? objAbort : 1'bX;
   endtask
endmodule

// [test/uus_user_unit_scaling_tb.sv]
/*
 Self-checking bench for the user-unit scaling block.
 Assumes the master model and the design constants header.
*/
`timescale 1ns/1ps
module uus_user_unit_scaling_tb;
   logic ref_clk = 1'b0, rst = 1'b1, opEnabled = 1'b0, velocityMode = 1'b0;
   logic openLoop = 1'b0, threePhase = 1'b0;
   logic objWr, objRd, objAck, objAbort, cfgPending, calcBusy, ab;
   logic [31:0] objRdData, rd;
   logic [31:0] num [7], den [7];
   uus_pkg::uus_obj_req_t  objReq;
   uus_pkg::uus_pos_info_t posInfo;
   uus_pkg::uus_spd_info_t spdInfo;
   uus_pkg::uus_ratios_t   ratios;
   int seed = 84373, miscompares = 0, total_checks = 0, cycles = 0, i, k, r;
   logic [7:0] pc [13] = '{8'h01, 8'hC1, 8'hC2, 8'h00, 8'h40, 8'h10, 8'h41, 8'h42,
      8'h43, 8'hB4, 8'hB5, 8'hAC, 8'hC0};
   logic [7:0] tc [5] = '{8'h03, 8'h47, 8'h48, 8'h49, 8'h4A};
   logic [15:0] ni [7] = '{16'h60E6, 16'h60E8, 16'h60E9, 16'h6096, 16'h6097, 16'h60A2, 16'h604C};
   logic [15:0] di [7] = '{16'h60EB, 16'h60ED, 16'h60EE, 16'h6096, 16'h6097, 16'h60A2, 16'h604C};

   uus_user_unit_scaling dut_u (.ref_clk(ref_clk), .rst(rst), .objWr(objWr), .objRd(objRd),
      .objReq(objReq), .objAck(objAck), .objAbort(objAbort), .objRdData(objRdData),
      .opEnabled(opEnabled), .velocityMode(velocityMode), .openLoop(openLoop),
      .threePhase(threePhase), .posInfo(posInfo), .spdInfo(spdInfo), .ratios(ratios),
      .cfgPending(cfgPending), .calcBusy(calcBusy));
   uus_master_model mst_u (.ref_clk(ref_clk), .objWr(objWr), .objRd(objRd), .objReq(objReq),
      .objAck(objAck), .objAbort(objAbort), .objRdData(objRdData));

   always #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         miscompares++;
         print_verdict();
      end
   end

   task automatic print_verdict;
      $display("Checks %0d, miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input logic [47:0] got, input logic [47:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d,
      input logic expAb);
      mst_u.access(1'b1, idx, sub, d, rd, ab);
      check(48'(ab), 48'(expAb));
   endtask
   task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp);
      mst_u.access(1'b0, idx, 8'h00, 32'h00000000, rd, ab);
      check({15'h0000, ab, rd}, {16'h0000, exp});
   endtask
   // Apply waits for a free divider, so poll pending and busy after a guard gap
   task automatic settle;
      int n;
      repeat (3) @(posedge ref_clk) #1;
      for (n = 0; n < 3000 && (cfgPending !== 1'b0 || calcBusy !== 1'b0); n++)
         @(posedge ref_clk) #1;
      repeat (3) @(posedge ref_clk) #1;
   endtask

   function automatic logic [1:0] useGF(input logic [7:0] c);
      case (c)
         8'h01, 8'hC1, 8'hC2, 8'h00: return 2'h3;
         8'hB5, 8'hAC, 8'hC0: return 2'h0;
         default: return 2'h2;
      endcase
   endfunction
   // Expected units per revolution with 50 pole pairs
   function automatic logic [47:0] perRev(input logic [7:0] c);
      case (c)
         8'hB5: return 48'h003200000000;
         8'hAC: return threePhase ? 48'h0000012C0000 : 48'h000000C80000;
         default: return 48'h000000320000;
      endcase
   endfunction
   function automatic logic [31:0] secs(input logic [7:0] t);
      case (t)
         8'h47: return 32'h0000003C;
         8'h48: return 32'h00000E10;
         8'h49: return 32'h00015180;
         8'h4A: return 32'h01E187E0;
         default: return 32'h00000001;
      endcase
   endfunction

   initial
   begin
      repeat (16) @(posedge ref_clk) #1;
      rst = 1'b0;
      rdchk(16'h60A8, 32'hFF410000);
      rdchk(16'h60A9, 32'h00B44700);
      wr(16'h60A8, 8'h00, 32'hFA41ABCD, 1'b0);
      rdchk(16'h60A8, 32'hFA410000);
      wr(16'h60A8, 8'h00, 32'hF9410000, 1'b1);
      wr(16'h60A8, 8'h00, 32'h07410000, 1'b1);
      wr(16'h60A8, 8'h00, 32'h06770000, 1'b1);
      wr(16'h60A9, 8'h00, 32'h060147AB, 1'b0);
      rdchk(16'h60A9, 32'h06014700);
      wr(16'h60A9, 8'h00, 32'h00010500, 1'b1);
      wr(16'h1234, 8'h00, 32'h00000000, 1'b1);
      wr(16'h2030, 8'h00, 32'h00000032, 1'b0);
      settle;
      check(48'(posInfo.expo), 48'h0000000000FA);
      opEnabled = 1'b1;
      wr(16'h60A8, 8'h00, 32'hFF400000, 1'b0);
      repeat (20) @(posedge ref_clk) #1;
      check({47'h0, cfgPending}, 48'h1);
      check(48'(posInfo.code), 48'h41);
      opEnabled = 1'b0;
      repeat (2) @(posedge ref_clk) #1;
      check({47'h0, calcBusy}, 48'h1);
      settle;
      check(48'(posInfo.code), 48'h40);
      openLoop = 1'b1;
      for (i = 0; i < 13; i++)
      begin
         threePhase = 1'($random(seed));
         wr(16'h60A8, 8'h00, {8'h00, pc[i], 16'h0000}, 1'b0);
         settle;
         check(48'({posInfo.useGear, posInfo.useFeed}), 48'(useGF(pc[i])));
         if (pc[i] inside {8'hB5, 8'hAC, 8'hC0})
            check(posInfo.perRevQ16, perRev(pc[i]));
      end
      openLoop = 1'b0;
      wr(16'h60A8, 8'h00, 32'h00B50000, 1'b0);
      settle;
      check(posInfo.perRevQ16, 48'h000000010000);
      for (i = 0; i < 5; i++)
      begin
         wr(16'h60A9, 8'h00, {8'hFD, 8'h01, tc[i], 8'h00}, 1'b0);
         settle;
         check({spdInfo.secPerUnit, spdInfo.timeCode, spdInfo.expo}, {secs(tc[i]), tc[i], 8'hFD});
      end
      velocityMode = 1'b1;
      repeat (3) @(posedge ref_clk) #1;
      check(48'({spdInfo.posCode, spdInfo.timeCode, spdInfo.expo}), 48'hB44700);
      velocityMode = 1'b0;
      for (r = 0; r < 2; r++)
      begin
         for (k = 0; k < 7; k++)
         begin
            num[k] = $random(seed);
            den[k] = (r == 1 && k == 5) ? 32'h0 : {16'h0000, 16'($random(seed))} | 32'h1;
            wr(ni[k], (k < 3) ? 8'h00 : 8'h01, num[k], 1'b0);
            wr(di[k], (k < 3) ? 8'h00 : 8'h02, den[k], 1'b0);
         end
         settle;
         for (k = 0; k < 7; k++)
            check(ratios[7 + 48 * (6 - k) +: 48], (den[k] == 0) ? 48'h0 : {num[k], 16'h0} / 48'(den[k]));
         check(48'(ratios.divZero), (r == 1) ? 48'h20 : 48'h0);
      end
      print_verdict();
   end
endmodule
